// >>> rtl/epcb_pkg.sv
// constants and types shared by the prom command and busy controller
package epcb_pkg;
	// timing: clock rate, serial clock half period, operation time-out
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCK_HALF_NS = 500;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] SCK_HALF_LAST = 6'(SCK_HALF_CYC - 1);
	localparam int OP_TIMEOUT_US = 30;
	localparam int OP_TIMEOUT_CYC = (OP_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	localparam logic [11:0] TMO_LAST = 12'(OP_TIMEOUT_CYC - 1);

	// register byte offsets
	localparam logic [7:0] ADDR_CMD = 8'hB0;
	localparam logic [7:0] ADDR_DATA = 8'hB4;
	localparam logic [7:0] ADDR_IRQ_STS = 8'hB8;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'hBC;

	// prom_command field positions
	localparam int CMD_BUSY_BIT = 31;
	localparam int CMD_OP_LSB = 28;
	localparam int CMD_TMO_BIT = 9;
	localparam int CMD_LOADED_BIT = 8;

	// interrupt status bit positions
	localparam int STS_DONE_BIT = 0;
	localparam int STS_TMO_BIT = 1;

	// reset values
	localparam logic CMD_BUSY_RST = 1'b1;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [1:0] IRQ_MSK_RST = 2'h0;

	// serial frame lengths and station address load
	localparam logic [4:0] HDR_BITS = 5'h0C;
	localparam logic [4:0] HDR_DATA_BITS = 5'h14;
	localparam logic [4:0] IN_BITS = 5'h08;
	localparam logic [2:0] MAC_BYTES_LAST = 3'h5;
	localparam logic [7:0] MAC_BASE_ADDR = 8'h01;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_ENABLE = 3'h1,
		OP_DISABLE = 3'h2,
		OP_WRITE = 3'h3,
		OP_WRALL = 3'h4,
		OP_ERASE = 3'h5,
		OP_ERALL = 3'h6,
		OP_RELOAD = 3'h7
	} epcb_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_OUT = 3'h1,
		ST_IN = 3'h2,
		ST_WAIT = 3'h3,
		ST_GAP = 3'h4
	} epcb_state_t;
endpackage

// >>> rtl/epcb_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module epcb_sync (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic d, // asynchronous level
	output logic q // synchronised level
);
	logic meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// >>> rtl/epcb_top.sv
// prom command register, busy flag, serial engine and apb slave
// Functional notes
// RL1: command register lives at B0h, 32 bits, controls reads and writes
// RL2: writing one to bit 31 starts selected operation at given address
// RL3: busy stays set through the operation, hardware clears it when done
// RL4: busy clearing after a read means data register holds valid contents
// RL5: software should not change command or data while busy is set
// RL6: write with no prom keeps busy until time-out, then clears it
// RL7: busy reads one immediately after power-up or reset
// RL8: after reset station address is loaded, busy cleared when load ends
// RL9: time-out length is a fixed counter set by a design constant
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module epcb_top
	import epcb_pkg::*;
(
	input wire logic mclk, // system clock, 100 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error for unmapped address
	output logic irq, // level interrupt, high while unmasked status set
	output logic prom_cs, // prom chip select
	output logic prom_sck, // prom serial clock
	output logic prom_do, // serial data to prom
	input wire logic prom_di, // serial data and ready from prom
	output logic [47:0] mac_addr, // loaded station address
	output logic mac_valid // station address load finished
);
	epcb_state_t state_q;
	epcb_op_t op_q;
	epcb_op_t cmd_op;
	logic busy_q, load_q, loaded_q, tmo_flag_q, ev_done_q, ev_tmo_q;
	logic cs_q, sck_q, do_q, di_s, pready_q, pslverr_q, irq_q, hit;
	logic [2:0] byte_q;
	logic [7:0] addr_q, data_q, in_sr_q;
	logic [5:0] div_q;
	logic [4:0] bit_q;
	logic [19:0] out_sr_q;
	logic [11:0] tmo_q;
	logic [47:0] mac_q;
	logic [31:0] prdata_q, rd_mux;
	logic [1:0] sts_q, msk_q, sts_d, msk_d, sts_clr;
	logic cap, acc, cmd_wr, data_wr, tick;
	logic fin_out, fin_in, fin_rdy, fin_tmo, fin_any;
	logic rst_seen_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// prom data pin comes from outside, so it is synchronised first
	epcb_sync u_di_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.d(prom_di),
		.q(di_s)
	);

	// ops that wait for the prom ready level afterwards
	function automatic logic waits_ready(input epcb_op_t op);
		waits_ready = (op == OP_WRITE) || (op == OP_WRALL) || (op == OP_ERASE) ||
			(op == OP_ERALL);
	endfunction

	// ops that shift a data byte after the header
	function automatic logic carries_data(input epcb_op_t op);
		carries_data = (op == OP_WRITE) || (op == OP_WRALL);
	endfunction

	// apb phases: one wait cycle so read data can come from a flop
	assign cap = psel && penable && !pready_q;
	assign acc = psel && penable && pready_q;
	// command and data are frozen while busy; writes then are dropped
	assign cmd_wr = acc && pwrite && (paddr == ADDR_CMD) && !busy_q; // RL5
	assign data_wr = acc && pwrite && (paddr == ADDR_DATA) && !busy_q;
	assign cmd_op = epcb_op_t'(pwdata[CMD_OP_LSB +: 3]);

	// read multiplexer and address decode
	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			ADDR_CMD: begin
				rd_mux[CMD_BUSY_BIT] = busy_q; // RL1
				rd_mux[CMD_OP_LSB +: 3] = op_q;
				rd_mux[CMD_TMO_BIT] = tmo_flag_q;
				rd_mux[CMD_LOADED_BIT] = loaded_q;
				rd_mux[7:0] = addr_q;
			end
			ADDR_DATA: rd_mux[7:0] = data_q;
			ADDR_IRQ_STS: rd_mux[1:0] = sts_q;
			ADDR_IRQ_MSK: rd_mux[1:0] = msk_q;
			default: hit = 1'b0;
		endcase
	end

	// apb answer registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q <= cap;
			if (cap) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_q <= !hit;
			end
		end
	end

	// serial clock divider ticks every half period
	assign tick = (div_q == SCK_HALF_LAST);

	// completion terms of the engine
	assign fin_out = (state_q == ST_OUT) && tick && sck_q && (bit_q == 5'h01) &&
		!load_q && (op_q != OP_READ) && !waits_ready(op_q);
	assign fin_in = (state_q == ST_IN) && tick && sck_q && (bit_q == 5'h01);
	assign fin_rdy = (state_q == ST_WAIT) && di_s;
	assign fin_tmo = (state_q == ST_WAIT) && !di_s && (tmo_q == TMO_LAST); // RL9
	assign fin_any = fin_out || fin_in || fin_rdy || fin_tmo;

	// command engine: busy flag, serial shifting, address load
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_GAP; // RL8
			busy_q <= CMD_BUSY_RST; // RL7
			load_q <= 1'b1;
			loaded_q <= 1'b0;
			byte_q <= 3'h0;
			op_q <= OP_READ;
			addr_q <= 8'h00;
			data_q <= DATA_RST;
			tmo_flag_q <= 1'b0;
			cs_q <= 1'b0;
			sck_q <= 1'b0;
			do_q <= 1'b0;
			div_q <= 6'h00;
			bit_q <= 5'h00;
			out_sr_q <= 20'h00000;
			in_sr_q <= 8'h00;
			tmo_q <= 12'h000;
			ev_done_q <= 1'b0;
			ev_tmo_q <= 1'b0;
			mac_q <= 48'h0000_0000_0000;
		end else if (ce) begin
			ev_done_q <= 1'b0;
			ev_tmo_q <= 1'b0;
			if (tick || state_q == ST_IDLE || state_q == ST_WAIT) begin
				div_q <= 6'h00;
			end else begin
				div_q <= div_q + 6'h01;
			end
			if (data_wr) begin
				data_q <= pwdata[7:0];
			end
			case (state_q)
				ST_IDLE: begin
					if (cmd_wr) begin // RL1
						op_q <= cmd_op;
						addr_q <= pwdata[7:0];
						if (pwdata[CMD_BUSY_BIT]) begin // RL2
							busy_q <= 1'b1; // RL3
							tmo_flag_q <= 1'b0;
							if (cmd_op == OP_RELOAD) begin
								load_q <= 1'b1;
								loaded_q <= 1'b0;
								byte_q <= 3'h0;
								state_q <= ST_GAP;
							end else begin
								cs_q <= 1'b1;
								out_sr_q <= {1'b1, cmd_op, pwdata[7:0], data_q};
								do_q <= 1'b1;
								bit_q <= carries_data(cmd_op) ? HDR_DATA_BITS : HDR_BITS;
								state_q <= ST_OUT;
							end
						end
					end
				end
				ST_GAP: begin
					// a half period with select low between address bytes
					if (tick) begin
						cs_q <= 1'b1;
						out_sr_q <= {1'b1, OP_READ, MAC_BASE_ADDR + {5'h00, byte_q}, 8'h00};
						do_q <= 1'b1;
						bit_q <= HDR_BITS;
						state_q <= ST_OUT;
					end
				end
				ST_OUT: begin
					if (tick) begin
						sck_q <= !sck_q;
						// data changes on the falling edge, prom samples on rising
						if (sck_q) begin
							if (bit_q == 5'h01) begin
								do_q <= 1'b0;
								if (load_q || op_q == OP_READ) begin
									bit_q <= IN_BITS;
									state_q <= ST_IN;
								end else if (waits_ready(op_q)) begin
									tmo_q <= 12'h000;
									state_q <= ST_WAIT;
								end
							end else begin
								out_sr_q <= {out_sr_q[18:0], 1'b0};
								do_q <= out_sr_q[18];
								bit_q <= bit_q - 5'h01;
							end
						end
					end
				end
				ST_IN: begin
					if (tick) begin
						sck_q <= !sck_q;
						if (!sck_q) begin
							in_sr_q <= {in_sr_q[6:0], di_s};
						end else begin
							bit_q <= bit_q - 5'h01;
						end
					end
				end
				ST_WAIT: begin
					// absent prom never shows ready, so the counter ends it
					tmo_q <= tmo_q + 12'h001; // RL6
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			// completion overrides the per-state updates above
			if (fin_any) begin
				cs_q <= 1'b0;
				sck_q <= 1'b0;
				do_q <= 1'b0;
				if (fin_in && load_q) begin
					mac_q[{byte_q, 3'h0} +: 8] <= in_sr_q;
					if (byte_q == MAC_BYTES_LAST) begin
						load_q <= 1'b0;
						loaded_q <= 1'b1;
						busy_q <= 1'b0; // RL8
						ev_done_q <= 1'b1;
						state_q <= ST_IDLE;
					end else begin
						byte_q <= byte_q + 3'h1;
						state_q <= ST_GAP;
					end
				end else begin
					if (fin_in) begin
						data_q <= in_sr_q; // RL4
					end
					busy_q <= 1'b0; // RL3
					ev_done_q <= !fin_tmo;
					ev_tmo_q <= fin_tmo; // RL6
					tmo_flag_q <= fin_tmo;
					state_q <= ST_IDLE;
				end
			end
		end
	end

	// status clear only drops bits the read actually returned
	always_comb begin
		sts_clr = 2'h0;
		if (acc && !pwrite && paddr == ADDR_IRQ_STS) begin
			sts_clr = prdata_q[1:0];
		end
		sts_d = (sts_q & ~sts_clr) | {ev_tmo_q, ev_done_q};
		msk_d = (acc && pwrite && paddr == ADDR_IRQ_MSK) ? pwdata[1:0] : msk_q;
	end

	// sticky status, mask and interrupt line; set beats clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sts_q <= 2'h0;
			msk_q <= IRQ_MSK_RST;
			irq_q <= 1'b0;
		end else if (ce) begin
			sts_q <= sts_d;
			msk_q <= msk_d;
			irq_q <= |(sts_d & msk_d);
		end
	end

	// helper: marks the first edge after reset release
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_seen_q <= 1'b0;
		end else if (ce) begin
			rst_seen_q <= 1'b1;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign prom_cs = cs_q;
	assign prom_sck = sck_q;
	assign prom_do = do_q;
	assign mac_addr = mac_q;
	assign mac_valid = loaded_q;

	sequence s_cmd_go;
		ce && cmd_wr && pwdata[CMD_BUSY_BIT];
	endsequence

	sequence s_launched;
		busy_q && (cs_q || state_q == ST_GAP);
	endsequence

	sequence s_cmd_capture;
		ce && cap && !pwrite && paddr == ADDR_CMD;
	endsequence

	AST_CMD_MAP: assert property (s_cmd_capture |=> // RL1
		prdata_q[CMD_BUSY_BIT] == $past(busy_q) && prdata_q[7:0] == $past(addr_q))
		else $error("command read does not show busy and address");

	AST_START: assert property (s_cmd_go |=> s_launched ##0 addr_q == $past(pwdata[7:0])) // RL2
		else $error("start bit did not launch the operation");

	AST_BUSY_CLEAR: assert property ($fell(busy_q) |-> ev_done_q || ev_tmo_q) // RL3
		else $error("busy cleared without a completion");

	AST_READ_DATA: assert property (ce && fin_in && !load_q |=> // RL4
		!busy_q && data_q == $past(in_sr_q))
		else $error("read finished without valid data");

	AST_TMO_END: assert property (ce && fin_tmo |=> !busy_q && ev_tmo_q && tmo_flag_q) // RL6
		else $error("time-out did not clear busy");

	AST_WAIT_BUSY: assert property (state_q == ST_WAIT |-> busy_q && tmo_q <= TMO_LAST) // RL9
		else $error("waiting without busy or counter overrun");

	AST_RESET_BUSY: assert property (!rst_seen_q |-> busy_q && load_q) // RL7
		else $error("busy not high after reset");

	AST_AUTOLOAD: assert property ($fell(load_q) |-> !busy_q && ev_done_q && mac_valid) // RL8
		else $error("address load ended without clearing busy");
endmodule

// >>> sim/epcb_prom_model.sv
// serial prom model: frame decoder, byte store, ready timing
`timescale 1ns/1ps
module epcb_prom_model (
	input wire logic mclk, // system clock
	input wire logic cs, // chip select
	input wire logic sck, // serial clock
	input wire logic sdi, // data from controller
	input wire logic stuck, // never report ready
	output logic sdo // data and ready level
);
	logic [7:0] mem [256];
	logic [19:0] sh = 20'h0;
	logic [7:0] ad = 8'h0;
	logic [2:0] op = 3'h0;
	logic drv = 1'h0, lvl = 1'h0, busy = 1'h0;
	int n = 0, wt = 0;
	// known contents, mirrored by the bench
	initial for (int a = 0; a < 256; a++) mem[a] = 8'(a * 37 + 17);
	// bits taken on sck rising, msb first
	always @(posedge sck) if (cs) begin
		sh = {sh[18:0], sdi};
		n = n + 1;
		if (n == 12) {op, ad} = sh[10:0];
		if (n == 20 && op inside {3'h3, 3'h4}) mem[ad] = sh[7:0];
		if ((n == 20 && op inside {3'h3, 3'h4}) || (n == 12 && op inside {3'h5, 3'h6})) begin
			busy = 1;
			wt = 200;
		end
	end
	// read bits leave on sck falling, ahead of the sampling edge
	always @(negedge sck) if (cs && op == 3'h0 && n >= 12 && n < 20) begin
		drv = 1;
		lvl = mem[ad][19 - n];
	end
	// ready low while busy; a released line floats to the pull-up level
	// runs on the falling clock so the controller never samples it mid-update
	always @(negedge mclk) begin
		if (!cs) begin
			n = 0;
			drv = 0;
			busy = 0;
		end
		if (busy) begin
			drv = 1;
			if (wt > 0) wt--;
			lvl = wt == 0 && !stuck;
		end
	end
	assign sdo = drv ? lvl : 1'b1;
endmodule

// >>> sim/epcb_top_test.sv
// self-checking bench for the prom command and busy controller
`timescale 1ns/1ps
module epcb_top_test
	import epcb_pkg::*;
;
	logic mclk, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, stuck = 1'h0;
	logic ce = 1'h1;
	logic [2:0] t;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h746175F2;
	logic pready, pslverr, irq, prom_cs, prom_sck, prom_do, prom_di, mac_valid, err;
	logic [47:0] mac_addr;
	int fail_count = 0, cmp_count = 0;
	int ref_mem [256];

	epcb_top i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .prom_cs(prom_cs), .prom_sck(prom_sck),
		.prom_do(prom_do), .prom_di(prom_di), .mac_addr(mac_addr), .mac_valid(mac_valid));
	epcb_prom_model i_prom (.mclk(mclk), .cs(prom_cs), .sck(prom_sck), .sdi(prom_do),
		.stuck(stuck), .sdo(prom_di));

	// free-running clock, 10 ns period
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic report_and_stop;
		if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; waits for pready without assuming a latency
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk) penable <= 1'h1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rd = prdata;
		err = pslverr;
		chk(pready, 1);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask

	// poll busy until it clears, bounded
	task automatic wait_idle(int lim);
		int k;
		k = 0;
		do begin
			apb(0, ADDR_CMD, 0);
			k++;
		end while (rd[31] !== 1'h0 && k < lim);
		chk(k < lim, 1);
	endtask

	task automatic cmd(logic [2:0] op, logic [7:0] a);
		apb(1, ADDR_CMD, {1'h1, op, 20'h0, a});
	endtask

	// hang guard, well past the expected run length
	initial begin
		#1000000;
		fail_count++;
		report_and_stop;
	end

	initial begin
		logic [7:0] a, d;
		for (int i = 0; i < 256; i++) ref_mem[i] = (i * 37 + 17) % 256;
		repeat (5) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		apb(0, ADDR_CMD, 0);
		chk(rd[31], 1);
		chk(rd[8], 0);
		chk(err, 0);
		wait_idle(4000);
		chk(mac_valid, 1);
		for (int b = 0; b < 6; b++) chk(mac_addr[8*b +: 8], ref_mem[1 + b]);
		// load-done event raises irq once unmasked; status read clears it
		apb(1, ADDR_IRQ_MSK, 1);
		chk(irq, 1);
		apb(0, ADDR_IRQ_STS, 0);
		chk(rd, 1);
		@(posedge mclk);
		chk(irq, 0);
		// random write then read back through the data register
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			a = seed[15:8];
			d = seed[7:0];
			apb(1, ADDR_DATA, d);
			cmd(OP_WRITE, a);
			apb(0, ADDR_CMD, 0);
			chk(rd[31], 1);
			wait_idle(1500);
			chk({prom_cs, prom_sck, prom_do}, 0);
			ref_mem[a] = d;
			cmd(OP_READ, a);
			wait_idle(1500);
			apb(0, ADDR_DATA, 0);
			chk(rd, ref_mem[a]);
		end
		// clock enable low freezes the frame part way through
		cmd(OP_READ, 8'h07);
		repeat (120) @(posedge mclk);
		ce <= 1'h0;
		@(posedge mclk);
		t = {prom_cs, prom_sck, prom_do};
		repeat (150) @(posedge mclk);
		chk({prom_cs, prom_sck, prom_do}, t);
		chk(t[2], 1);
		ce <= 1'h1;
		wait_idle(1500);
		apb(0, ADDR_DATA, 0);
		chk(rd, ref_mem[7]);
		// reload restarts the address load and drops the valid flag
		cmd(OP_RELOAD, 8'h00);
		chk(mac_valid, 0);
		wait_idle(4000);
		chk(rd[8], 1);
		for (int b = 0; b < 6; b++) chk(mac_addr[8*b +: 8], ref_mem[1 + b]);
		// control and erase codes each end with busy low and no time-out
		for (int j = 1; j < 7; j++) if (j != 3 && j != 4) begin
			cmd(3'(j), 8'h40);
			wait_idle(1500);
			chk(rd[9], 0);
			chk(rd[30:28], j);
		end
		// a prom that never reports ready: busy holds until the time-out
		apb(1, ADDR_IRQ_MSK, 3);
		apb(0, ADDR_IRQ_STS, 0);
		stuck <= 1'h1;
		cmd(OP_WRITE, 8'h40);
		// a command while busy must be dropped by the controller
		cmd(OP_READ, 8'h07);
		repeat (4800) @(posedge mclk);
		apb(0, ADDR_CMD, 0);
		chk(rd[31], 1);
		wait_idle(200);
		chk(rd[9], 1);
		chk(rd[7:0], 8'h40);
		chk(rd[30:28], OP_WRITE);
		chk(irq, 1);
		apb(0, ADDR_IRQ_STS, 0);
		chk(rd[1], 1);
		chk(rd[0], 0);
		stuck <= 1'h0;
		// unmapped place answers with an error and reads zero
		apb(1, 8'hC0, 32'h1234);
		chk(err, 1);
		apb(0, 8'hC0, 0);
		chk(err, 1);
		chk(rd, 0);
		// second reset mid-run brings busy back
		rst_n <= 1'h0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		chk(mac_valid, 0);
		apb(0, ADDR_CMD, 0);
		chk(rd[31], 1);
		report_and_stop;
	end
endmodule
